//--- src/mfc_map.svh
// Register offsets, codes, field positions and timing counts of the fault control bank
`ifndef MFC_MAP_SVH
`define MFC_MAP_SVH

`define MFC_ADDR_CONN_TIMEOUT   16'h0500
`define MFC_ADDR_WDOG_TIMEOUT   16'h07D0
`define MFC_ADDR_FAULT_MODE     16'h07D2
`define MFC_ADDR_FAULT_REASON   16'h07D4
`define MFC_ADDR_COMMAND        16'h07D6
`define MFC_ADDR_STATUS         16'h1F3C
`define MFC_ADDR_OUT_DATA       16'h2328

`define MFC_EXC_NONE            8'h00
`define MFC_EXC_ADDRESS         8'h02
`define MFC_EXC_VALUE           8'h03

`define MFC_MODE_ALL_LOW        16'h0000
`define MFC_MODE_ALL_HIGH       16'h0001
`define MFC_MODE_HOLD           16'h0002

`define MFC_REASON_NONE         16'h0000
`define MFC_REASON_LINK         16'h0007
`define MFC_REASON_HOST         16'h0008
`define MFC_REASON_USER         16'h0009
`define MFC_REASON_ABORT        16'h000A
`define MFC_REASON_INIT         16'h000B
`define MFC_REASON_WDOG         16'h000C
`define MFC_REASON_CONN         16'h000D

`define MFC_CMD_SET_BIT         4
`define MFC_CMD_ACK_BIT         5
`define MFC_CMD_WARN_CLR_BIT    7

`define MFC_STAT_ERROR_BIT      0
`define MFC_STAT_NETFAIL_BIT    1

`define MFC_TIMEOUT_RESET       16'h0000
`define MFC_MS_NS               1000000
`define MFC_CLK_NS              8
`define MFC_MS_CYCLES           (`MFC_MS_NS / `MFC_CLK_NS)

`endif

//--- src/mfc_pkg.sv
// Types shared by the fault control register bank
package mfc_pkg;

    typedef struct packed {
        logic        write;
        logic [2:0]  conn;
        logic [15:0] addr;
        logic [15:0] data;
    } mfc_req_s;

    typedef struct packed {
        logic [15:0] data;
        logic [7:0]  exc;
    } mfc_rsp_s;

    typedef struct packed {
        logic data_transfer_link_timeout;
        logic host_timeout;
        logic conn_abort;
        logic init_error;
    } mfc_ext_s;

    typedef enum logic [0:0] {
        MFC_RUN  = 1'b0,
        MFC_FAIL = 1'b1
    } mfc_state_e;

endpackage : mfc_pkg

//--- src/mfc_regs.sv
// Fault control register bank: timeouts, watchdog, net fault state and substitute outputs
// Functional notes
// - Writes to read-only registers store nothing and answer exception 02.
// - Connection timeout of zero disables monitoring of a connection once it runs a function.
// - New connection timeout applies only after a function on that connection.
// - Watchdog timeout zero disables watchdog; nonzero arms it with that period.
// - Fault mode 0 drives outputs low, 1 high, 2 holds last value.
// - Reason codes 07 transfer, 08 host, 09 user, 0A abort, 0B init.
// - Reason 0C for watchdog expiry, 0D for connection monitoring timeout.
// - Reason codes 01 through 06 are never reported.
// - Command register is write only; reads return no stored contents.
// - Command write with more than one bit set is rejected with error.
// - Command bit 4 forces net fault; bit 5 acknowledges and clears it.
// - Command bit 7 clears latched I/O warning indication.
// - Status bit 0 is one while any error is pending.
// - Status bit 1 is one while net fault and substitutes are active.
// - Armed watchdog starts on first output write, restarts on output writes, not reads.
// - Watchdog expiry applies substitute outputs and sets net fault.
// - Auto mode clears fault on next output write; manual needs acknowledge command.
// - Acknowledge restarts the watchdog for a fresh period.
`include "mfc_map.svh"

module mfc_regs #(
    parameter int MS_CYCLES = `MFC_MS_CYCLES,
    parameter int N_CONN    = 8,
    parameter int OUT_W     = 8
) (
    input  wire logic              ref_clk,
    input  wire logic              reset,
    input  wire logic              req_valid,
    input  wire mfc_pkg::mfc_req_s req,
    input  wire logic              auto_ack,
    input  wire logic [N_CONN-1:0] conn_open,
    input  wire mfc_pkg::mfc_ext_s ext_fault,
    input  wire logic              io_warn,
    input  wire logic [15:0]       diag_bits,
    output logic                   rsp_valid,
    output mfc_pkg::mfc_rsp_s      rsp,
    output logic [OUT_W-1:0]       dout,
    output logic                   net_fail
);

    function automatic logic one_hot(input logic [15:0] v);
        one_hot = (v != 16'h0000) && ((v & (v - 16'h0001)) == 16'h0000);
    endfunction : one_hot

    logic [15:0]        conn_to_r;
    logic [15:0]        wdog_to_r;
    logic [15:0]        mode_r;
    logic [15:0]        reason_r;
    logic [OUT_W-1:0]   out_data_r;
    logic               warn_r;
    mfc_pkg::mfc_state_e state_r;
    logic [31:0]        ms_cnt_r;
    logic               ms_tick;
    logic [15:0]        act_to_r [N_CONN];
    logic [15:0]        conn_cnt_r [N_CONN];
    logic               wd_started_r;
    logic [15:0]        wd_cnt_r;

    logic [15:0] rdata;
    logic [7:0]  exc;
    logic        wr_conn;
    logic        wr_wdog;
    logic        wr_mode;
    logic        wr_out;
    logic        cmd_set;
    logic        cmd_ack;
    logic        cmd_warn;
    logic        conn_expire;
    logic        wd_expire;
    logic        fault_set;
    logic        fault_clr;
    logic [15:0] set_code;
    logic [15:0] status_word;

    assign status_word = {14'h0000, state_r == mfc_pkg::MFC_FAIL,
                          warn_r | (|diag_bits)};

    // Millisecond enable pulse for both timeout engines
    always_ff @(posedge ref_clk)
    begin
        if (reset || ms_cnt_r == 32'(MS_CYCLES - 1))
            ms_cnt_r <= 32'h0000_0000;
        else
            ms_cnt_r <= ms_cnt_r + 32'h0000_0001;
    end

    assign ms_tick = (ms_cnt_r == 32'(MS_CYCLES - 1));

    // Request decode; nothing is stored when an exception is answered
    always_comb
    begin
        rdata    = 16'h0000;
        exc      = `MFC_EXC_NONE;
        wr_conn  = 1'b0;
        wr_wdog  = 1'b0;
        wr_mode  = 1'b0;
        wr_out   = 1'b0;
        cmd_set  = 1'b0;
        cmd_ack  = 1'b0;
        cmd_warn = 1'b0;
        if (req_valid)
        begin
            if (req.addr == `MFC_ADDR_CONN_TIMEOUT)
            begin
                wr_conn = req.write;
                rdata   = conn_to_r;
            end
            else if (req.addr == `MFC_ADDR_WDOG_TIMEOUT)
            begin
                wr_wdog = req.write;
                rdata   = wdog_to_r;
            end
            else if (req.addr == `MFC_ADDR_FAULT_MODE)
            begin
                rdata = mode_r;
                if (req.write && req.data > `MFC_MODE_HOLD)
                    exc = `MFC_EXC_VALUE;
                else
                    wr_mode = req.write;
            end
            else if (req.addr == `MFC_ADDR_FAULT_REASON)
            begin
                if (req.write)
                    exc = `MFC_EXC_ADDRESS;
                else
                    rdata = reason_r;
            end
            else if (req.addr == `MFC_ADDR_COMMAND)
            begin
                if (!req.write)
                    exc = `MFC_EXC_ADDRESS;
                else if (req.data != 16'h0000 && !one_hot(req.data))
                    exc = `MFC_EXC_VALUE;
                else
                begin
                    // Lone reserved bits fall through with no effect
                    cmd_set  = req.data[`MFC_CMD_SET_BIT];
                    cmd_ack  = req.data[`MFC_CMD_ACK_BIT];
                    cmd_warn = req.data[`MFC_CMD_WARN_CLR_BIT];
                end
            end
            else if (req.addr == `MFC_ADDR_STATUS)
            begin
                if (req.write)
                    exc = `MFC_EXC_ADDRESS;
                else
                    rdata = status_word;
            end
            else if (req.addr == `MFC_ADDR_OUT_DATA)
            begin
                wr_out = req.write;
                rdata  = {{(16 - OUT_W){1'b0}}, out_data_r};
            end
            else
            begin
                exc = `MFC_EXC_ADDRESS;
            end
        end
    end

    // Configuration registers
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            conn_to_r <= `MFC_TIMEOUT_RESET;
            wdog_to_r <= `MFC_TIMEOUT_RESET;
            mode_r    <= `MFC_MODE_ALL_LOW;
        end
        else
        begin
            if (wr_conn)
                conn_to_r <= req.data;
            if (wr_wdog)
                wdog_to_r <= req.data;
            if (wr_mode)
                mode_r <= req.data;
        end
    end

    // Output image, high byte ignored on write
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            out_data_r <= '0;
        else if (wr_out)
            out_data_r <= req.data[OUT_W-1:0];
    end

    // Connection monitoring: each connection keeps the timeout it last used
    always_ff @(posedge ref_clk)
    begin
        for (int i = 0; i < N_CONN; i++)
        begin
            if (reset || !conn_open[i])
            begin
                act_to_r[i]   <= `MFC_TIMEOUT_RESET;
                conn_cnt_r[i] <= 16'h0000;
            end
            else if (req_valid && req.conn == 3'(i))
            begin
                act_to_r[i]   <= conn_to_r;
                conn_cnt_r[i] <= 16'h0000;
            end
            else if (ms_tick && act_to_r[i] != 16'h0000 && conn_cnt_r[i] < act_to_r[i])
            begin
                conn_cnt_r[i] <= conn_cnt_r[i] + 16'h0001;
            end
        end
    end

    // Expiry is a single pulse; counter then parks at the limit
    always_comb
    begin
        conn_expire = 1'b0;
        for (int i = 0; i < N_CONN; i++)
        begin
            if (conn_open[i] && ms_tick && act_to_r[i] != 16'h0000 &&
                !(req_valid && req.conn == 3'(i)) &&
                conn_cnt_r[i] + 16'h0001 == act_to_r[i])
                conn_expire = 1'b1;
        end
    end

    // Process data watchdog; cannot be halted except by zero period
    always_ff @(posedge ref_clk)
    begin
        if (reset || wdog_to_r == 16'h0000)
        begin
            wd_started_r <= 1'b0;
            wd_cnt_r     <= 16'h0000;
        end
        else if (wr_out || fault_clr)
        begin
            wd_started_r <= 1'b1;
            wd_cnt_r     <= 16'h0000;
        end
        else if (wd_started_r && ms_tick && wd_cnt_r < wdog_to_r)
        begin
            wd_cnt_r <= wd_cnt_r + 16'h0001;
        end
    end

    assign wd_expire = wd_started_r && !wr_out && !fault_clr && ms_tick &&
                       wd_cnt_r + 16'h0001 == wdog_to_r;

    // Cause priority when several arrive together; only codes 07..0D exist
    always_comb
    begin
        set_code = `MFC_REASON_NONE;
        if (wd_expire)
            set_code = `MFC_REASON_WDOG;
        else if (conn_expire)
            set_code = `MFC_REASON_CONN;
        else if (cmd_set)
            set_code = `MFC_REASON_USER;
        else if (ext_fault.data_transfer_link_timeout)
            set_code = `MFC_REASON_LINK;
        else if (ext_fault.host_timeout)
            set_code = `MFC_REASON_HOST;
        else if (ext_fault.conn_abort)
            set_code = `MFC_REASON_ABORT;
        else if (ext_fault.init_error)
            set_code = `MFC_REASON_INIT;
    end

    assign fault_set = (set_code != `MFC_REASON_NONE);
    assign fault_clr = (state_r == mfc_pkg::MFC_FAIL) &&
                       (cmd_ack || (auto_ack && wr_out));

    // Net fault state; a new cause wins over a same-cycle acknowledge
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            state_r  <= mfc_pkg::MFC_RUN;
            reason_r <= `MFC_REASON_NONE;
        end
        else
        begin
            case (state_r)
                mfc_pkg::MFC_RUN:
                begin
                    if (fault_set)
                    begin
                        state_r  <= mfc_pkg::MFC_FAIL;
                        reason_r <= set_code;
                    end
                end
                mfc_pkg::MFC_FAIL:
                begin
                    if (fault_set)
                        reason_r <= set_code;
                    else if (fault_clr)
                        state_r <= mfc_pkg::MFC_RUN;
                end
                default:
                begin
                    state_r <= mfc_pkg::MFC_RUN;
                end
            endcase
        end
    end

    // Latched I/O warning; a new warning wins over the clear command
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            warn_r <= 1'b0;
        else if (io_warn)
            warn_r <= 1'b1;
        else if (cmd_warn)
            warn_r <= 1'b0;
    end

    // Physical outputs; substitute values replace the image while failed
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            dout <= '0;
        else if (state_r == mfc_pkg::MFC_FAIL)
        begin
            if (mode_r == `MFC_MODE_ALL_HIGH)
                dout <= '1;
            else if (mode_r == `MFC_MODE_ALL_LOW)
                dout <= '0;
        end
        else
            dout <= out_data_r;
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            net_fail <= 1'b0;
        else
            net_fail <= fault_set || (state_r == mfc_pkg::MFC_FAIL && !fault_clr);
    end

    // Answer one cycle after the request
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            rsp_valid <= 1'b0;
            rsp       <= '0;
        end
        else
        begin
            rsp_valid <= req_valid;
            rsp.data  <= req_valid ? rdata : 16'h0000;
            rsp.exc   <= req_valid ? exc : `MFC_EXC_NONE;
        end
    end

endmodule : mfc_regs

//--- testbench/mfc_regs_sva.sv
// Port assertions for the fault control register bank
`include "mfc_map.svh"

module mfc_regs_sva #(
    parameter int MS_CYCLES = `MFC_MS_CYCLES,
    parameter int N_CONN    = 8,
    parameter int OUT_W     = 8
) (
    input wire logic              ref_clk,
    input wire logic              reset,
    input wire logic              req_valid,
    input wire mfc_pkg::mfc_req_s req,
    input wire logic              auto_ack,
    input wire logic [N_CONN-1:0] conn_open,
    input wire mfc_pkg::mfc_ext_s ext_fault,
    input wire logic              io_warn,
    input wire logic [15:0]       diag_bits,
    input wire logic              rsp_valid,
    input wire mfc_pkg::mfc_rsp_s rsp,
    input wire logic [OUT_W-1:0]  dout,
    input wire logic              net_fail
);
    logic rd;
    logic cmd;
    logic quiet;
    assign rd    = req_valid && !req.write;
    assign cmd   = req_valid && req.write && req.addr == `MFC_ADDR_COMMAND;
    // Other fault causes in the same cycle would legally win over an ack
    assign quiet = ext_fault == '0;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    property p_ro;
        req_valid && req.write && req.addr inside {`MFC_ADDR_FAULT_REASON, `MFC_ADDR_STATUS}
        |=> rsp.exc == `MFC_EXC_ADDRESS;
    endproperty
    a_ro: assert property (p_ro) else $error("read-only write not refused");
    property p_cmd_rd;
        rd && req.addr == `MFC_ADDR_COMMAND |=> rsp.exc == `MFC_EXC_ADDRESS && rsp.data == 16'h0000;
    endproperty
    a_cmd_rd: assert property (p_cmd_rd) else $error("command read answered");
    property p_multi;
        cmd && $countones(req.data) > 1 |=> rsp.exc == `MFC_EXC_VALUE && $stable(net_fail);
    endproperty
    a_multi: assert property (p_multi) else $error("multi-bit command taken");
    property p_set; cmd && req.data == 16'h0010 |=> net_fail ##1 net_fail; endproperty
    a_set: assert property (p_set) else $error("set command ignored");
    property p_ack; cmd && req.data == 16'h0020 && quiet |=> !net_fail; endproperty
    a_ack: assert property (p_ack) else $error("ack command ignored");
    property p_rsv;
        rd && req.addr == `MFC_ADDR_FAULT_REASON |=> !(rsp.data inside {[16'h0001:16'h0006]});
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved reason code seen");
    property p_stat;
        rd && req.addr == `MFC_ADDR_STATUS
        |=> rsp.data[15:2] == 14'h0000 && rsp.data[1] == $past(net_fail);
    endproperty
    a_stat: assert property (p_stat) else $error("status word wrong");
    property p_err; rd && req.addr == `MFC_ADDR_STATUS && diag_bits != 16'h0000 |=> rsp.data[0];
    endproperty
    a_err: assert property (p_err) else $error("error bit missing");
    property p_auto;
        auto_ack && net_fail && quiet && req_valid && req.write
        && req.addr == `MFC_ADDR_OUT_DATA |=> !net_fail;
    endproperty
    a_auto: assert property (p_auto) else $error("auto ack failed");

    c_set: cover property (cmd && req.data == 16'h0010);
    c_rise: cover property ($rose(net_fail));
    c_fall: cover property ($fell(net_fail));
endmodule : mfc_regs_sva

//--- testbench/mfc_client.sv
// Modbus client model issuing single word requests
module mfc_client (
    input  wire logic              ref_clk,
    output mfc_pkg::mfc_req_s      req,
    output logic                   req_valid,
    input  wire logic              rsp_valid,
    input  wire mfc_pkg::mfc_rsp_s rsp
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        req_valid = 1'b0;
        req = '0;
    end

    // Answer is due on the very next edge; a missing one reads as FF
    task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d,
                        output logic [15:0] q, output logic [7:0] x);
        @(posedge ref_clk);
        #1;
        req_valid = 1'b1;
        req = '{write: w, conn: 3'h0, addr: a, data: d};
        @(posedge ref_clk);
        #1;
        req_valid = 1'b0;
        // Released address and data lines show inverted values, not a stale copy
        req.addr = ~a;
        req.data = ~d;
        q = rsp.data;
        x = rsp_valid ? rsp.exc : 8'hFF;
    endtask : xfer
endmodule : mfc_client

//--- testbench/testbench.sv
// Self-checking bench for the fault control register bank
`include "mfc_map.svh"

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MS = 10;
    localparam int LIMIT = 30000;
    logic              ref_clk = 1'b0;
    logic              reset = 1'b1;
    logic              req_valid;
    mfc_pkg::mfc_req_s req;
    logic              auto_ack = 1'b0;
    logic [7:0]        conn_open = 8'h01;
    mfc_pkg::mfc_ext_s ext_fault = '0;
    logic              io_warn = 1'b0;
    logic [15:0]       diag_bits = 16'h0000;
    logic              rsp_valid;
    mfc_pkg::mfc_rsp_s rsp;
    logic [7:0]        dout;
    logic              net_fail;
    int                n_fail = 0;
    int                num_checks = 0;
    int                cyc = 0;

    mfc_regs #(.MS_CYCLES(MS)) dut (.ref_clk, .reset, .req_valid, .req, .auto_ack,
        .conn_open, .ext_fault, .io_warn, .diag_bits, .rsp_valid, .rsp, .dout, .net_fail);
    mfc_client u_cli (.ref_clk, .req, .req_valid, .rsp_valid, .rsp);

    always #4 ref_clk = ~ref_clk;

    task automatic print_verdict();
        if (n_fail == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict

    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == LIMIT)
        begin
            n_fail++;
            print_verdict();
        end
    end

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic chk_nf(input logic e);
        chk("net_fail", {15'h0000, e}, {15'h0000, net_fail});
    endtask : chk_nf

    task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic [7:0] ex);
        logic [15:0] q;
        logic [7:0]  x;
        u_cli.xfer(1'b1, a, d, q, x);
        chk("write exc", {8'h00, ex}, {8'h00, x});
    endtask : wr

    task automatic rd(input logic [15:0] a, input logic [15:0] e, input logic [7:0] ex);
        logic [15:0] q;
        logic [7:0]  x;
        u_cli.xfer(1'b0, a, 16'h0000, q, x);
        chk("read exc", {8'h00, ex}, {8'h00, x});
        chk("read data", e, q);
    endtask : rd

    // Polling reads on the way must not restart the watchdog
    task automatic wait_nf(input int lo, input int hi, input logic poll);
        int          t0;
        logic [15:0] q;
        logic [7:0]  x;
        t0 = cyc;
        while (net_fail !== 1'b1 && cyc - t0 < hi + 10)
            if (poll)
                u_cli.xfer(1'b0, `MFC_ADDR_STATUS, 16'h0000, q, x);
            else
            begin
                @(posedge ref_clk);
                #1;
            end
        chk("fault delay", 16'h0001, {15'h0000, cyc - t0 >= lo && cyc - t0 <= hi});
    endtask : wait_nf

    task automatic t_regs();
        rd(`MFC_ADDR_FAULT_REASON, 16'h0000, 8'h00);
        wr(`MFC_ADDR_FAULT_REASON, 16'h0009, 8'h02);
        wr(`MFC_ADDR_STATUS, 16'h0003, 8'h02);
        rd(`MFC_ADDR_FAULT_REASON, 16'h0000, 8'h00);
        rd(`MFC_ADDR_STATUS, 16'h0000, 8'h00);
        rd(`MFC_ADDR_COMMAND, 16'h0000, 8'h02);
        rd(16'h0600, 16'h0000, 8'h02);
        wr(`MFC_ADDR_FAULT_MODE, 16'h0003, 8'h03);
        wr(`MFC_ADDR_WDOG_TIMEOUT, 16'hFDE8, 8'h00);
        rd(`MFC_ADDR_WDOG_TIMEOUT, 16'hFDE8, 8'h00);
        wr(`MFC_ADDR_WDOG_TIMEOUT, 16'h0000, 8'h00);
    endtask : t_regs

    task automatic t_modes();
        logic [7:0] sub [3] = '{8'h00, 8'hFF, 8'h5A};
        wr(`MFC_ADDR_COMMAND, 16'h0030, 8'h03);
        wr(`MFC_ADDR_COMMAND, 16'h0001, 8'h00);
        chk_nf(1'b0);
        for (int m = 0; m < 3; m++)
        begin
            wr(`MFC_ADDR_FAULT_MODE, 16'(m), 8'h00);
            wr(`MFC_ADDR_OUT_DATA, 16'h005A, 8'h00);
            wr(`MFC_ADDR_COMMAND, 16'h0010, 8'h00);
            rd(`MFC_ADDR_FAULT_REASON, `MFC_REASON_USER, 8'h00);
            rd(`MFC_ADDR_STATUS, 16'h0002, 8'h00);
            wr(`MFC_ADDR_OUT_DATA, 16'h00C3, 8'h00);
            chk("dout", {8'h00, sub[m]}, {8'h00, dout});
            chk_nf(1'b1);
            wr(`MFC_ADDR_COMMAND, 16'h0020, 8'h00);
            chk_nf(1'b0);
            @(posedge ref_clk);
            #1;
            chk("dout", 16'h00C3, {8'h00, dout});
        end
    endtask : t_modes

    task automatic t_ext();
        logic [15:0] code [4] = '{16'h0007, 16'h0008, 16'h000A, 16'h000B};
        for (int i = 0; i < 4; i++)
        begin
            @(posedge ref_clk);
            #1;
            ext_fault = mfc_pkg::mfc_ext_s'(4'h8 >> i);
            @(posedge ref_clk);
            #1;
            ext_fault = '0;
            chk_nf(1'b1);
            rd(`MFC_ADDR_FAULT_REASON, code[i], 8'h00);
            wr(`MFC_ADDR_COMMAND, 16'h0020, 8'h00);
        end
    endtask : t_ext

    task automatic t_diag();
        diag_bits = 16'h0004;
        rd(`MFC_ADDR_STATUS, 16'h0001, 8'h00);
        diag_bits = 16'h0000;
        io_warn = 1'b1;
        rd(`MFC_ADDR_STATUS, 16'h0001, 8'h00);
        io_warn = 1'b0;
        wr(`MFC_ADDR_COMMAND, 16'h0080, 8'h00);
        rd(`MFC_ADDR_STATUS, 16'h0000, 8'h00);
    endtask : t_diag

    task automatic t_wdog();
        auto_ack = 1'b1;
        wr(`MFC_ADDR_FAULT_MODE, `MFC_MODE_ALL_HIGH, 8'h00);
        wr(`MFC_ADDR_WDOG_TIMEOUT, 16'h00C8, 8'h00);
        wr(`MFC_ADDR_OUT_DATA, 16'h0011, 8'h00);
        wait_nf(200 * MS - 20, 200 * MS + 5, 1'b1);
        rd(`MFC_ADDR_FAULT_REASON, `MFC_REASON_WDOG, 8'h00);
        chk("dout", 16'h00FF, {8'h00, dout});
        wr(`MFC_ADDR_OUT_DATA, 16'h0022, 8'h00);
        chk_nf(1'b0);
        auto_ack = 1'b0;
        wait_nf(200 * MS - 20, 200 * MS + 5, 1'b0);
        wr(`MFC_ADDR_OUT_DATA, 16'h0033, 8'h00);
        chk_nf(1'b1);
        wr(`MFC_ADDR_COMMAND, 16'h0020, 8'h00);
        wait_nf(200 * MS - 20, 200 * MS + 5, 1'b0);
        wr(`MFC_ADDR_COMMAND, 16'h0020, 8'h00);
        wr(`MFC_ADDR_WDOG_TIMEOUT, 16'h0000, 8'h00);
        repeat (250 * MS) @(posedge ref_clk);
        #1;
        chk_nf(1'b0);
    endtask : t_wdog

    task automatic t_conn();
        wr(`MFC_ADDR_CONN_TIMEOUT, 16'h00C8, 8'h00);
        // The write itself still ran under the old, disabled timeout
        repeat (250 * MS) @(posedge ref_clk);
        #1;
        chk_nf(1'b0);
        rd(`MFC_ADDR_CONN_TIMEOUT, 16'h00C8, 8'h00);
        wait_nf(200 * MS - 20, 200 * MS + 5, 1'b0);
        rd(`MFC_ADDR_FAULT_REASON, `MFC_REASON_CONN, 8'h00);
        wr(`MFC_ADDR_CONN_TIMEOUT, 16'h0000, 8'h00);
        wr(`MFC_ADDR_COMMAND, 16'h0020, 8'h00);
        rd(`MFC_ADDR_CONN_TIMEOUT, 16'h0000, 8'h00);
        repeat (250 * MS) @(posedge ref_clk);
        #1;
        chk_nf(1'b0);
    endtask : t_conn

    initial
    begin
        repeat (3) @(posedge ref_clk);
        #1;
        reset = 1'b0;
        t_regs();
        t_modes();
        t_ext();
        t_diag();
        t_wdog();
        t_conn();
        print_verdict();
    end
endmodule : testbench

bind mfc_regs mfc_regs_sva #(.MS_CYCLES(MS_CYCLES), .N_CONN(N_CONN), .OUT_W(OUT_W)) u_sva (
    .ref_clk, .reset, .req_valid, .req, .auto_ack, .conn_open, .ext_fault, .io_warn,
    .diag_bits, .rsp_valid, .rsp, .dout, .net_fail);
